// ==== shared/bbcf_defs.vh ====
// Constants for the burst bus configuration field block.
// Included by the core; holds definitions only.
`ifndef BBCF_DEFS_VH
`define BBCF_DEFS_VH

// Register selection
`define BBCF_SEL_BUS_CONFIG 2'h2
`define BBCF_SW_CODE_BUS_CONFIG 16'h0001
`define BBCF_BUS_CONFIG_RESET 16'h9D1F

// Field positions
`define BBCF_DRIVE_HI 5
`define BBCF_DRIVE_LO 4
`define BBCF_STALL_TIMING 8
`define BBCF_STALL_POL 10
`define BBCF_LAT_HI 13
`define BBCF_LAT_LO 11
`define BBCF_INIT_LAT 14
`define BBCF_OP_MODE 15

// Drive strength codes
`define BBCF_DRIVE_FULL 2'h0
`define BBCF_DRIVE_HALF 2'h1
`define BBCF_DRIVE_QUARTER 2'h2
`define BBCF_DRIVE_RSVD 2'h3

// Latency codes and counts
`define BBCF_LAT_CODE_2 3'h2
`define BBCF_LAT_CODE_3 3'h3
`define BBCF_LAT_CODE_4 3'h4
`define BBCF_LAT_CODE_5 3'h5
`define BBCF_LAT_CODE_6 3'h6
`define BBCF_LAT_VAR2_COLL 3'h4
`define BBCF_LAT_VAR3_COLL 3'h6

`endif

// ==== core/bbcf_core.v ====
// Bus configuration register upper fields and the burst timing they steer.
// Assumes the controller logic runs on clk, so its strobes need no
// synchronising; burst pins are driven by that controller.
//
// Function
// - Drive field: 00 full, 01 half default, 10 quarter, 11 reserved.
// - Stall timing 0: data and stall change on the same edge.
// - Stall timing 1 default: stall changes one clock before data.
// - Polarity bit picks stall level when asserted; high by default.
// - Three-bit latency code sets clocks from burst start to data.
// - First data word comes the cycle after the latency count.
// - Variable: 010 gives 2 or 4, 011 gives 3 or 6; others reserved.
// - Fixed: codes 010 to 110 give counts 2 to 6; others reserved.
// - Initial-latency bit selects variable (default) or fixed latency.
// - Variable latency stretches on refresh collision, shown on stall.
// - Fixed latency always uses its worst-case count; stall optional.
// - Mode bit selects synchronous burst or asynchronous (default).
// - Register selected by select pin with address 10, or code 0001.
// - Register loads 9D1F at power-up.
//
// Reserved latency codes behave as the default count; a reserved drive
// code leaves the drive field as it was.
`timescale 1ns/100ps
`include "bbcf_defs.vh"

module bbcf_core (
  input wire clk, // System clock, 100 MHz
  input wire reset_n, // Asynchronous reset, active low
  input wire config_register_select, // Register access select pin
  input wire [1:0] addr_hi, // Address bits 19:18
  input wire reg_write, // Pin-path register write strobe
  input wire reg_read, // Pin-path register read strobe
  input wire sw_write, // Software sequence write, third cycle
  input wire sw_read, // Software sequence read, third cycle
  input wire [15:0] sw_code, // Data on third cycle of sequence
  input wire [15:0] wr_data, // Register write data
  input wire burst_start, // Burst initiation, one-cycle pulse
  input wire burst_stop, // Ends the burst, one-cycle pulse
  input wire refresh_collision, // Refresh collides with this access
  output reg [15:0] rd_data_q, // Register read data
  output reg rd_valid_q, // Read data valid, one cycle
  output reg [1:0] drive_strength_q, // Effective output drive code
  output reg sync_mode_q, // High in synchronous burst mode
  output reg stall_q, // Stall indicator pin level
  output reg data_valid_q // Burst data bus valid
);

  // ******************************************************************
  // Register selection and storage
  // ******************************************************************
  reg [15:0] bus_configuration_q;
  reg [15:0] bus_configuration_d;
  wire pin_sel;
  wire sw_sel;
  wire wr_hit;
  wire rd_hit;

  assign pin_sel = config_register_select &&
                   (addr_hi == `BBCF_SEL_BUS_CONFIG);
  assign sw_sel = (sw_code == `BBCF_SW_CODE_BUS_CONFIG);
  assign wr_hit = (pin_sel && reg_write) || (sw_sel && sw_write);
  assign rd_hit = (pin_sel && reg_read) || (sw_sel && sw_read);

  always @* begin
    bus_configuration_d = bus_configuration_q;
    if (wr_hit) begin
      bus_configuration_d = wr_data;
      if (wr_data[`BBCF_DRIVE_HI:`BBCF_DRIVE_LO] == `BBCF_DRIVE_RSVD) begin
        bus_configuration_d[`BBCF_DRIVE_HI:`BBCF_DRIVE_LO] =
          bus_configuration_q[`BBCF_DRIVE_HI:`BBCF_DRIVE_LO];
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_configuration_q <= `BBCF_BUS_CONFIG_RESET;
    end else begin
      bus_configuration_q <= bus_configuration_d;
    end
  end

  // Read strobe echoes as a one-cycle valid
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_hit;
    end
  end

  // Read data holds until the next read
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= 16'h0000;
    end else if (rd_hit) begin
      rd_data_q <= bus_configuration_q;
    end
  end

  // ******************************************************************
  // Field decode
  // ******************************************************************
  wire [2:0] lat_code;
  wire fixed_lat;
  wire stall_early;
  wire stall_act_high;
  reg [2:0] lat_count;

  assign lat_code = bus_configuration_q[`BBCF_LAT_HI:`BBCF_LAT_LO];
  assign fixed_lat = bus_configuration_q[`BBCF_INIT_LAT];
  assign stall_early = bus_configuration_q[`BBCF_STALL_TIMING];
  assign stall_act_high = bus_configuration_q[`BBCF_STALL_POL];

  // ******************************************************************
  // Latency count selection
  // ******************************************************************
  reg [2:0] lat_fixed;
  reg [2:0] lat_var;

  // Reserved codes fall back to the default count so a bad write
  // cannot hang a burst.
  // Fixed counts already cover the worst-case refresh collision.
  // fixed counts, collision ignored
  always @* begin
    lat_fixed = `BBCF_LAT_CODE_3;
    case (lat_code)
      `BBCF_LAT_CODE_2: begin
        lat_fixed = `BBCF_LAT_CODE_2;
      end
      `BBCF_LAT_CODE_3: begin
        lat_fixed = `BBCF_LAT_CODE_3;
      end
      `BBCF_LAT_CODE_4: begin
        lat_fixed = `BBCF_LAT_CODE_4;
      end
      `BBCF_LAT_CODE_5: begin
        lat_fixed = `BBCF_LAT_CODE_5;
      end
      `BBCF_LAT_CODE_6: begin
        lat_fixed = `BBCF_LAT_CODE_6;
      end
      default: begin
        lat_fixed = `BBCF_LAT_CODE_3;
      end
    endcase
  end

  // Variable counts double when a refresh collides.
  // variable counts, stretched on collision
  always @* begin
    lat_var = `BBCF_LAT_CODE_3;
    case (lat_code)
      `BBCF_LAT_CODE_2: begin
        if (refresh_collision) begin
          lat_var = `BBCF_LAT_VAR2_COLL;
        end else begin
          lat_var = `BBCF_LAT_CODE_2;
        end
      end
      default: begin
        if (refresh_collision) begin
          lat_var = `BBCF_LAT_VAR3_COLL;
        end else begin
          lat_var = `BBCF_LAT_CODE_3;
        end
      end
    endcase
  end

  // Collision only matters at the start edge, where the count loads
  always @* begin
    lat_count = fixed_lat ? lat_fixed : lat_var;
  end

  // ******************************************************************
  // Burst latency sequencer
  // ******************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_LAT = 2'h1;
  localparam ST_DATA = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [2:0] cnt_q;
  reg [2:0] cnt_d;
  reg stall_d;
  wire sync_mode;

  // mode bit 0 is synchronous burst
  assign sync_mode = ~bus_configuration_q[`BBCF_OP_MODE];

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (burst_start && sync_mode) begin
          state_d = ST_LAT;
          cnt_d = lat_count;
        end
      end
      ST_LAT: begin
        if (burst_stop) begin
          state_d = ST_IDLE;
        end else if (cnt_q == 3'h0) begin
          state_d = ST_DATA;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      ST_DATA: begin
        if (burst_stop || !sync_mode) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Stall asserts while the next state waits for data; the early
  // setting also drops it once the count has reached zero.
  always @* begin
    stall_d = (state_d == ST_LAT);
    if (stall_early && state_d == ST_LAT && cnt_d == 3'h0 &&
        state_q == ST_LAT) begin
      stall_d = 1'b0;
    end
  end

  // ******************************************************************
  // Sequencer and output registers
  // ******************************************************************
  // Sequencer state
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Counts down; zero moves the burst into its data phase
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // data phase follows the next state
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_valid_q <= 1'b0;
    end else begin
      data_valid_q <= (state_d == ST_DATA);
    end
  end

  // Registered so the pin cannot glitch while the next state settles
  // polarity of asserted level
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stall_q <= 1'b0;
    end else begin
      stall_q <= stall_act_high ? stall_d : ~stall_d;
    end
  end

  // One cycle behind the register, like the mode flag output
  // drive strength out
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_strength_q <= `BBCF_DRIVE_HALF;
    end else begin
      drive_strength_q <= bus_configuration_q[`BBCF_DRIVE_HI:`BBCF_DRIVE_LO];
    end
  end

  // Lags the register by one cycle like the drive output
  // mode flag out
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_mode_q <= 1'b0;
    end else begin
      sync_mode_q <= sync_mode;
    end
  end

endmodule

// ==== tb/bbcf_sva.sv ====
// Checker for the burst configuration block.
// Sees only core ports; bound to the core below.
`timescale 1ns/100ps
module bbcf_sva (
  input wire clk, // Clock
  input wire reset_n, // Reset
  input wire config_register_select, // Select pin
  input wire [1:0] addr_hi, // Address
  input wire reg_write, // Write strobe
  input wire reg_read, // Read strobe
  input wire [15:0] wr_data, // Write data
  input wire burst_start, // Start
  input wire burst_stop, // Stop
  input wire rd_valid_q, // Read valid
  input wire [1:0] drive_strength_q, // Drive code
  input wire sync_mode_q, // Burst mode
  input wire stall_q, // Stall pin
  input wire data_valid_q // Data phase
);
  wire hit = config_register_select && addr_hi == 2'h2;
  wire [1:0] wr_drive = wr_data[5:4];
  wire wr_mode = wr_data[15];
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rd; hit && reg_read |=> rd_valid_q; endproperty
  a_rd: assert property (p_rd) else $error("no read data");
  property p_rsvd; drive_strength_q != 2'h3; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved drive");
  property p_drv; hit && reg_write && wr_drive != 2'h3
    |-> ##2 drive_strength_q == $past(wr_drive, 2); endproperty
  a_drv: assert property (p_drv) else $error("drive code");
  property p_mode; hit && reg_write
    |-> ##2 sync_mode_q == !$past(wr_mode, 2); endproperty
  a_mode: assert property (p_mode) else $error("mode bit");
  property p_stop; data_valid_q && burst_stop |=> !data_valid_q; endproperty
  a_stop: assert property (p_stop) else $error("data after stop");
  property p_hold; data_valid_q && !burst_stop |=> data_valid_q; endproperty
  a_hold: assert property (p_hold) else $error("data dropped");
  property p_edge; $rose(data_valid_q)
    |-> $changed(stall_q) || $past(stall_q) != $past(stall_q, 2); endproperty
  a_edge: assert property (p_edge) else $error("stall edge");
  property p_lat; burst_start && sync_mode_q && !data_valid_q
    |=> !data_valid_q [*2] ##[1:6] data_valid_q; endproperty
  a_lat: assert property (p_lat) else $error("latency");
endmodule
bind bbcf_core bbcf_sva i_bbcf_sva (.*);

// ==== tb/bbcf_ctrl_model.sv ====
// Memory controller model on the burst pins.
// Runs bursts on clk at 100 MHz, so every latency code is legal.
`timescale 1ns/100ps
module bbcf_ctrl_model (
  input wire clk, // Burst clock
  input wire stall_q, // Stall pin
  input wire data_valid_q, // Data phase
  output reg burst_start = 1'b0, // Start pulse
  output reg burst_stop = 1'b0, // Stop pulse
  output reg refresh_collision = 1'b0 // Collision level
);
  task run(input col, input pol, output int n_dv, output int n_st);
    int i;
    n_dv = 0;
    n_st = 0;
    @(posedge clk);
    burst_start <= 1'b1;
    refresh_collision <= col;
    @(posedge clk);
    burst_start <= 1'b0;
    refresh_collision <= 1'b0;
    for (i = 1; i < 12 && n_dv == 0; i++) begin
      #1;
      if (n_st == 0 && stall_q !== pol) n_st = i;
      if (data_valid_q === 1'b1) n_dv = i;
      @(posedge clk);
    end
    burst_stop <= 1'b1;
    @(posedge clk);
    burst_stop <= 1'b0;
  endtask
endmodule

// ==== tb/bbcf_core_tb.sv ====
// Bench for the burst configuration block.
// Registers via select pin or software code; bursts via the model.
`timescale 1ns/100ps
module bbcf_core_tb;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg config_register_select = 1'b0;
  reg [1:0] addr_hi = 2'h0;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg sw_write = 1'b0;
  reg sw_read = 1'b0;
  reg [15:0] sw_code = 16'h0000;
  reg [15:0] wr_data = 16'h0000;
  wire burst_start, burst_stop, refresh_collision;
  wire [15:0] rd_data_q;
  wire rd_valid_q, sync_mode_q, stall_q, data_valid_q;
  wire [1:0] drive_strength_q;
  int fails = 0;
  int checks_done = 0;
  int n_dv, n_st;
  always #5 clk = ~clk;
  bbcf_core i_bbcf_core (.*);
  bbcf_ctrl_model i_bbcf_ctrl_model (.*);
  task chk(input [15:0] got, input [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One register cycle; r reads, s uses the software path
  task xfer(input r, input s, input [1:0] a, input [15:0] c, input [15:0] d);
    @(posedge clk);
    config_register_select <= !s;
    addr_hi <= a;
    sw_code <= c;
    wr_data <= d;
    reg_read <= r && !s;
    reg_write <= !r && !s;
    sw_read <= r && s;
    sw_write <= !r && s;
    @(posedge clk);
    {reg_read, reg_write, sw_read, sw_write} <= 4'h0;
    config_register_select <= 1'b0;
    #1;
  endtask
  task t_reset;
    xfer(1, 0, 2'h2, 16'h0000, 16'h0000);
    @(posedge clk);
    #1;
    chk(rd_data_q, 16'h9D1F);
    chk(16'(drive_strength_q), 16'h0001);
    chk(16'(sync_mode_q), 16'h0000);
    i_bbcf_ctrl_model.run(1'b0, 1'b1, n_dv, n_st);
    chk(16'(n_dv), 16'h0000);
  endtask
  task t_drive;
    int c;
    for (c = 0; c < 4; c++) begin
      xfer(0, c[0], 2'h2, 16'h0001, 16'h9D0F | 16'(c << 4));
      repeat (2) @(posedge clk);
      #1;
      chk(16'(drive_strength_q), (c == 3) ? 16'h0002 : 16'(c));
    end
  endtask
  task t_select;
    xfer(0, 0, 2'h0, 16'h0000, 16'h0000);
    xfer(0, 1, 2'h2, 16'h0002, 16'h0000);
    xfer(1, 0, 2'h1, 16'h0000, 16'h0000);
    @(posedge clk);
    #1;
    chk(16'(rd_valid_q), 16'h0000);
    xfer(1, 1, 2'h0, 16'h0001, 16'h0000);
    @(posedge clk);
    #1;
    chk(rd_data_q, 16'h9D2F);
  endtask
  task t_latency;
    int i, code, lat;
    bit fix, col, pol, t8;
    for (i = 0; i < 9; i++) begin
      fix = i > 3;
      code = fix ? i - 2 : 2 + i / 2;
      col = i[0];
      pol = i[1];
      t8 = i[2] ^ i[0];
      lat = (col && !fix) ? 2 * code : code;
      xfer(0, 0, 2'h2, 16'h0000, {1'b0, fix, 3'(code), pol, 1'b0, t8, 8'h1F});
      repeat (3) @(posedge clk);
      #1;
      chk(16'(stall_q), 16'(!pol));
      i_bbcf_ctrl_model.run(col, pol, n_dv, n_st);
      // Model counts the start edge, where the count loads, as one
      chk(16'(n_dv), 16'(lat + 2));
      chk(16'(n_st), 16'(t8 ? lat + 1 : lat + 2));
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_drive;
    t_select;
    t_latency;
    report_and_stop;
  end
endmodule
